// *** bench/host_port.sv ***
/*
 * Host-side model of the three-wire port: drives sclk, select and data.
 * Assumes clk_i is the system clock and line_i the resolved data wire.
 */
`timescale 1ns/1ps
module host_port (
	// system
	input  wire logic clk_i,
	// serial wire
	input  wire logic line_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      d_o,
	output logic      oe_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		d_o    = 1'b0;
		oe_o   = 1'b0;
	end
	// sclk period 8 clk (160 ns); read bits are taken as sclk rises, the port's
	// drive may end a few clocks after the last rise of a read
	task automatic bits(input logic [7:0] tx, input logic lsb, input logic rd, input int nb,
		output logic [7:0] rx);
		int k;
		rx = 8'h00;
		for (int i = 0; i < nb; i++) begin
			k = lsb ? i : 7 - i;
			sclk_o = 1'b0;
			oe_o   = !rd;
			d_o    = tx[k];
			repeat (4) @(negedge clk_i);
			rx[k]  = line_i;
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_i);
		end
	endtask
	// last byte may be cut short to force a mid-byte select rise
	task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] adr,
		input logic lsb, input int n, input logic [31:0] wd, output logic [31:0] q,
		input int last_nb);
		logic [15:0] ins;
		logic [7:0]  r;
		ins = {rd, len, adr};
		q = 32'h0;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		bits(lsb ? ins[7:0] : ins[15:8], lsb, 1'b0, 8, r);
		bits(lsb ? ins[15:8] : ins[7:0], lsb, 1'b0, 8, r);
		for (int b = 0; b < n; b++) begin
			bits(wd[8*b +: 8], lsb, rd, (b == n - 1) ? last_nb : 8, r);
			q[8*b +: 8] = r;
		end
		sclk_o = 1'b0;
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		oe_o   = 1'b0;
		repeat (8) @(negedge clk_i);
	endtask
endmodule // host_port

// *** bench/tb.sv ***
/*
 * Self-checking bench for serial_config_port with a host model.
 * Assumes a short power-on hold parameter; the unselected wire toggles.
 */
`timescale 1ns/1ps
module tb;
	import scp_pkg::*;
	localparam int HOLD = 20;
	logic        clk;
	logic        rst;
	logic        keep;
	logic        line;
	logic        sclk, cs_n, h_d, h_oe, sdio_o, sdio_oe_o;
	logic        cal_done_o, cal_fail_o, pll_enable_o;
	ref_seen_t   refs;
	logic [NREG*8-1:0] active_cfg_o;
	logic [31:0] q;
	logic [7:0]  r;
	int          err_total;
	int          comparisons;
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		keep = 1'b0;
		refs = 3'b100;
		err_total = 0;
		comparisons = 0;
	end
	always #10 clk = ~clk;
	always @(posedge clk) keep <= ~keep;
	assign line = sdio_oe_o ? sdio_o : (h_oe ? h_d : keep);
	serial_config_port #(.POR_HOLD(HOLD)) serial_config_port_inst (.clk_i(clk), .rst_i(rst),
		.sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(line), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
		.ref_seen_i(refs), .active_cfg_o(active_cfg_o), .cal_done_o(cal_done_o),
		.cal_fail_o(cal_fail_o), .pll_enable_o(pll_enable_o));
	host_port host_port_inst (.clk_i(clk), .line_i(line), .sclk_o(sclk), .cs_n_o(cs_n),
		.d_o(h_d), .oe_o(h_oe));
	function automatic logic [7:0] act(input int a);
		return active_cfg_o[a*8 +: 8];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [1:0] len, input logic lsb, input int n,
		input logic [31:0] d);
		host_port_inst.xfer(1'b0, len, a, lsb, n, d, q, 8);
	endtask
	task automatic pulse_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
	endtask
	task automatic t_power();
		chk(32'(act(0)), 32'h0);
		chk(32'(sdio_oe_o), 32'h0);
		repeat (HOLD + CAL_CYCLES - 10) @(negedge clk);
		chk(32'(cal_done_o), 32'h0);
		repeat (20) @(negedge clk);
		chk(32'({cal_fail_o, cal_done_o, pll_enable_o}), 32'h3);
	endtask
	task automatic t_buffer();
		wr(13'h0012, 2'h2, 1'b0, 3, 32'h00C3B2A1);
		chk(32'({act(18), act(17), act(16)}), 32'h0);
		wr(UPDATE_ADDR, 2'h0, 1'b0, 1, 32'h1);
		chk(32'({act(18), act(17), act(16)}), 32'hA1B2C3);
		host_port_inst.xfer(1'b1, 2'h2, 13'h0012, 1'b0, 3, 32'h0, q, 8);
		chk(q, 32'h00C3B2A1);
	endtask
	task automatic t_status();
		wr(STATUS_ADDR, 2'h0, 1'b0, 1, 32'hFF);
		wr(UPDATE_ADDR, 2'h0, 1'b0, 1, 32'h1);
		host_port_inst.xfer(1'b1, 2'h0, STATUS_ADDR, 1'b0, 1, 32'h0, q, 8);
		chk(q, 32'h01);
		// readback of the shadow copy: a pending write is visible before update
		wr(READBACK_ADDR, 2'h0, 1'b0, 1, 32'h1);
		wr(UPDATE_ADDR, 2'h0, 1'b0, 1, 32'h1);
		wr(13'h0011, 2'h0, 1'b0, 1, 32'h77);
		host_port_inst.xfer(1'b1, 2'h0, 13'h0011, 1'b0, 1, 32'h0, q, 8);
		chk(q, 32'h77);
		chk(32'(act(17)), 32'hB2);
	endtask
	task automatic t_ignore();
		host_port_inst.bits(8'h00, 1'b0, 1'b0, 8, r);
		host_port_inst.bits(8'h12, 1'b0, 1'b0, 8, r);
		host_port_inst.bits(8'h5A, 1'b0, 1'b0, 8, r);
		chk(32'(sdio_oe_o), 32'h0);
		wr(UPDATE_ADDR, 2'h0, 1'b0, 1, 32'h1);
		chk(32'(act(18)), 32'hA1);
	endtask
	task automatic t_abort();
		// a port left mid-byte would swallow the update below; the cut byte is dropped, so 0x20 stays 0
		wr(13'h0021, 2'h0, 1'b0, 1, 32'h3C);
		host_port_inst.xfer(1'b0, 2'h0, 13'h0020, 1'b0, 1, 32'hFF, q, 4);
		wr(UPDATE_ADDR, 2'h0, 1'b0, 1, 32'h1);
		chk(32'({act(33), act(32)}), 32'h3C00);
	endtask
	task automatic t_lsb();
		wr(CFG_ADDR, 2'h0, 1'b0, 1, 32'h40);
		wr(UPDATE_ADDR, 2'h0, 1'b0, 1, 32'h1);
		wr(13'h0022, 2'h1, 1'b1, 2, 32'h2211);
		wr(UPDATE_ADDR, 2'h0, 1'b1, 1, 32'h1);
		chk(32'({act(35), act(34)}), 32'h2211);
	endtask
	task automatic t_noref();
		refs = 3'b000;
		pulse_reset();
		chk(32'(act(0)), 32'h0);
		repeat (HOLD + CAL_CYCLES + 20) @(negedge clk);
		chk(32'({cal_fail_o, cal_done_o, pll_enable_o}), 32'h6);
		// reference turns up late: only a fresh reset reruns calibration
		refs = 3'b001;
		pulse_reset();
		chk(32'({cal_fail_o, cal_done_o}), 32'h0);
		repeat (HOLD + CAL_CYCLES + 20) @(negedge clk);
		chk(32'({cal_fail_o, cal_done_o, pll_enable_o}), 32'h3);
	endtask
	task automatic results();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_power();
		t_buffer();
		t_status();
		t_ignore();
		t_abort();
		t_lsb();
		t_noref();
		results();
	end
	// whole sequence needs under 10000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		results();
	end
endmodule // tb

// *** hw/scp_pkg.sv ***
/*
 * Constants and carrier types for the three-wire serial configuration port.
 * Assumes a 50 MHz system clock; all pin inputs are asynchronous to it.
 */
package scp_pkg;
	localparam int          CLK_MHZ       = 50;
	localparam int          POR_TIME_US   = 250;
	localparam int          POR_CYCLES    = POR_TIME_US * CLK_MHZ;
	localparam int          CAL_TIME_US   = 10;
	localparam int          CAL_CYCLES    = CAL_TIME_US * CLK_MHZ;
	localparam int          ADDR_W        = 13;
	localparam int          NREG          = 53;
	localparam logic [12:0] LAST_ADDR     = 13'h0034;
	localparam logic [12:0] CFG_ADDR      = 13'h0000;
	localparam int          LSB_FIRST_BIT = 6;
	localparam logic [12:0] READBACK_ADDR = 13'h0004;
	localparam int          READBACK_BIT  = 0;
	localparam logic [12:0] UPDATE_ADDR   = 13'h0005;
	localparam int          UPDATE_BIT    = 0;
	localparam logic [12:0] STATUS_ADDR   = 13'h0034;
	localparam logic [7:0]  RESET_VALUE   = 8'h00;
	localparam logic [3:0]  INSTR_LAST    = 4'hF;
	localparam logic [2:0]  BYTE_LAST     = 3'h7;
	localparam logic [1:0]  LEN_STREAM    = 2'h3;

	typedef struct packed {
		logic              rd;
		logic [1:0]        len;
		logic [ADDR_W-1:0] addr;
	} instr_t;

	typedef struct packed {
		logic primary;
		logic secondary;
		logic crystal;
	} ref_seen_t;

	typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} port_state_t;
endpackage

// *** hw/serial_config_port.sv ***
/*
 * Three-wire serial configuration port with double-buffered registers,
 * power-on hold and automatic VCO calibration sequencing.
 * Assumes serial pins and reference-present levels are asynchronous and are
 * oversampled by clk_i (serial clock well below clk_i / 4).
 */
// How it works
// - read-only registers have no buffer, ignore writes
// - writes land in shadow; active changes on update
// - writing one to 0x05 bit0 triggers update
// - one update applies all shadow changes together
// - write bits sampled on serial clock rise
// - read bits change on serial clock fall
// - data line undriven while select high
// - select low frames every transfer; else ignored
// - 16-bit instruction reaches addresses 0x00 to 0x34
// - one two-way data line, in and out
// - single/multi byte, msb or lsb first
// - power-up calibration runs when reference present
// - no reference: calibration fails, PLL unlocked
// - power-on hold of about 250 us
// - instruction: read bit, length, 13-bit address
// - length 00/01/10 = 1/2/3 bytes, 11 streams
// - address decrements msb-first, increments lsb-first
// - select rising mid-byte aborts, drops partial byte
`timescale 1ns/1ps
module serial_config_port #(
	parameter int POR_HOLD = scp_pkg::POR_CYCLES
) (
	// system
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// serial pins
	input  wire logic                     sclk_i,
	input  wire logic                     cs_n_i,
	input  wire logic                     sdio_i,
	output logic                          sdio_o,
	output logic                          sdio_oe_o,
	// reference presence levels
	input  wire scp_pkg::ref_seen_t       ref_seen_i,
	// configuration and status
	output logic [scp_pkg::NREG*8-1:0]    active_cfg_o,
	output logic                          cal_done_o,
	output logic                          cal_fail_o,
	output logic                          pll_enable_o
);
	import scp_pkg::*;

	logic [2:0]       sclk_m;
	logic             cs_m, cs_s, cs_d, sdio_m, sdio_s, sclk_s, sclk_d;
	ref_seen_t        ref_m, ref_s;
	logic             rise, fall, cs_rise, busy_rst, lsb, byte_done, wr_en, upd;
	logic [13:0]      por_cnt;
	logic [9:0]       cal_cnt;
	logic             cal_run;
	port_state_t      state;
	logic [3:0]       cnt;
	logic [15:0]      sh, next_sh;
	logic [7:0]       wr_byte, out_sh, rd_next;
	instr_t           ins, next_ins;
	logic [1:0]       left;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [7:0]       shadow [0:NREG-1];
	logic [7:0]       active [0:NREG-1];

	// two-stage synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_i) begin
		sclk_m <= {sclk_m[1:0], sclk_i};
		cs_m   <= cs_n_i;
		cs_s   <= cs_m;
		cs_d   <= cs_s;
		sdio_m <= sdio_i;
		sdio_s <= sdio_m;
		ref_m  <= ref_seen_i;
		ref_s  <= ref_m;
	end
	assign sclk_s  = sclk_m[1];
	assign sclk_d  = sclk_m[2];
	assign rise    = sclk_s & ~sclk_d & ~cs_s;
	assign fall    = ~sclk_s & sclk_d & ~cs_s;
	assign cs_rise = cs_s & ~cs_d;

	// power-on hold: internal reset stays on after the pin releases
	always_ff @(posedge clk_i) begin
		if (rst_i)
			por_cnt <= 14'(POR_HOLD);
		else if (por_cnt != '0)
			por_cnt <= por_cnt - 14'h1;
	end
	assign busy_rst = rst_i | (por_cnt != '0);

	// calibration runs once after the hold; only a reset reruns it
	always_ff @(posedge clk_i) begin
		if (busy_rst) begin
			cal_run    <= 1'b1;
			cal_cnt    <= 10'(CAL_CYCLES);
			cal_done_o <= 1'b0;
			cal_fail_o <= 1'b0;
		end else if (cal_run) begin
			cal_cnt <= cal_cnt - 10'h1;
			if (cal_cnt == 10'h1) begin
				cal_run    <= 1'b0;
				cal_done_o <= 1'b1;
				cal_fail_o <= (ref_s == '0);
			end
		end
	end
	assign pll_enable_o = cal_done_o & ~cal_fail_o;

	assign lsb     = active[CFG_ADDR[5:0]][LSB_FIRST_BIT];
	assign next_sh = lsb ? {sdio_s, sh[15:1]} : {sh[14:0], sdio_s};
	assign wr_byte = lsb ? next_sh[15:8] : next_sh[7:0];
	assign next_ins = instr_t'(next_sh);
	assign byte_done = rise && state == ST_DATA && cnt[2:0] == BYTE_LAST;
	assign wr_en   = byte_done && !ins.rd;
	assign next_addr = lsb ? addr + 13'h1 : addr - 13'h1;

	function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
		if (a == STATUS_ADDR)
			read_reg = {6'h00, cal_fail_o, cal_done_o};
		else if (a > LAST_ADDR)
			read_reg = 8'h00;
		else if (active[READBACK_ADDR[5:0]][READBACK_BIT])
			read_reg = shadow[a[5:0]];
		else
			read_reg = active[a[5:0]];
	endfunction
	assign rd_next = read_reg(state == ST_INSTR ? next_ins.addr : next_addr);

	// transfer sequencer
	always_ff @(posedge clk_i) begin
		if (busy_rst) begin
			state  <= ST_INSTR;
			cnt    <= '0;
			sh     <= '0;
			ins    <= '0;
			addr   <= '0;
			left   <= '0;
			out_sh <= '0;
		end else if (cs_rise && (state == ST_DONE || cnt[2:0] != '0
				|| (state == ST_DATA && ins.len == LEN_STREAM))) begin
			state <= ST_INSTR;
			cnt   <= '0;
		end else if (rise) begin
			sh  <= next_sh;
			cnt <= cnt + 4'h1;
			if (state == ST_INSTR && cnt == INSTR_LAST) begin
				ins    <= next_ins;
				addr   <= next_ins.addr;
				left   <= next_ins.len;
				state  <= ST_DATA;
				cnt    <= '0;
				out_sh <= rd_next;
			end else if (byte_done) begin
				addr   <= next_addr;
				out_sh <= rd_next;
				if (ins.len != LEN_STREAM) begin
					left <= left - 2'h1;
					if (left == 2'h0)
						state <= ST_DONE;
				end
			end
		end
	end

	// read data leaves on the falling edge so it is stable at the next rise
	always_ff @(posedge clk_i) begin
		if (busy_rst) begin
			sdio_o <= 1'b0;
		end else if (fall && state == ST_DATA && ins.rd) begin
			sdio_o <= lsb ? out_sh[cnt[2:0]] : out_sh[BYTE_LAST - cnt[2:0]];
		end
	end
	assign sdio_oe_o = ~cs_s && state == ST_DATA && ins.rd;

	// shadow copy; update bit is self-clearing and never held
	always_ff @(posedge clk_i) begin
		if (busy_rst) begin
			for (int i = 0; i < NREG; i++)
				shadow[i] <= RESET_VALUE;
		end else if (wr_en && addr <= LAST_ADDR && addr != STATUS_ADDR) begin
			shadow[addr[5:0]] <= wr_byte;
			if (addr == UPDATE_ADDR)
				shadow[addr[5:0]][UPDATE_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (busy_rst)
			upd <= 1'b0;
		else
			upd <= wr_en && addr == UPDATE_ADDR && wr_byte[UPDATE_BIT];
	end

	// active copy moves as a whole, one cycle after the update write
	always_ff @(posedge clk_i) begin
		if (busy_rst) begin
			for (int i = 0; i < NREG; i++)
				active[i] <= RESET_VALUE;
		end else if (upd) begin
			for (int i = 0; i < NREG; i++)
				active[i] <= shadow[i];
		end
	end

	always_comb begin
		for (int i = 0; i < NREG; i++)
			active_cfg_o[i*8 +: 8] = active[i];
	end

	sequence s_update_write;
		wr_en && addr == UPDATE_ADDR && wr_byte[UPDATE_BIT];
	endsequence
	sequence s_midbyte_rise;
		cs_rise && state != ST_DONE && cnt[2:0] != '0;
	endsequence

	property p_ro_ignored;
		@(posedge clk_i) disable iff (busy_rst)
		wr_en && addr == STATUS_ADDR |=> shadow[STATUS_ADDR[5:0]] == RESET_VALUE;
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write stored");

	property p_active_hold;
		@(posedge clk_i) disable iff (busy_rst)
		!upd |=> active_cfg_o == $past(active_cfg_o);
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("active changed without update");

	property p_update_fires;
		@(posedge clk_i) disable iff (busy_rst)
		s_update_write |=> upd ##1 (active[CFG_ADDR[5:0]] == shadow[CFG_ADDR[5:0]]);
	endproperty
	a_update_fires: assert property (p_update_fires) else $error("update not applied");

	property p_oe_select;
		@(posedge clk_i) disable iff (rst_i)
		cs_s |-> !sdio_oe_o;
	endproperty
	a_oe_select: assert property (p_oe_select) else $error("data line driven while idle");

	property p_out_on_fall;
		@(posedge clk_i) disable iff (busy_rst)
		$changed(sdio_o) |-> $past(fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("read bit moved off falling edge");

	property p_idle_ignored;
		@(posedge clk_i) disable iff (busy_rst)
		cs_s && cs_d |=> $stable(cnt) && $stable(state);
	endproperty
	a_idle_ignored: assert property (p_idle_ignored) else $error("activity while deselected");

	property p_midbyte_abort;
		@(posedge clk_i) disable iff (busy_rst)
		s_midbyte_rise |=> state == ST_INSTR && cnt == '0;
	endproperty
	a_midbyte_abort: assert property (p_midbyte_abort) else $error("mid-byte abort missed");

	property p_addr_step;
		@(posedge clk_i) disable iff (busy_rst)
		byte_done |=> addr == ($past(lsb) ? $past(addr) + 13'h1 : $past(addr) - 13'h1);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address step wrong");

	property p_por_hold;
		@(posedge clk_i)
		$fell(rst_i) |-> busy_rst [*8];
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("power-on hold too short");

	property p_cal_fail;
		@(posedge clk_i) disable iff (busy_rst)
		cal_run && cal_cnt == 10'h1 && ref_s == '0 |=> cal_fail_o && !pll_enable_o;
	endproperty
	a_cal_fail: assert property (p_cal_fail) else $error("missing reference not reported");

	property p_reset_clears;
		@(posedge clk_i)
		rst_i |=> state == ST_INSTR && active_cfg_o == '0 && !sdio_oe_o;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear port");
endmodule // serial_config_port
